// [rtl/kli_defines.vh]
// register offsets, reset values and widths for the keypad level interrupt block
// assumes inclusion by bare name from the design files
`ifndef KLI_DEFINES_VH
`define KLI_DEFINES_VH
`define KLI_ADDR_W 8
`define KLI_DATA_W 8
`define KLI_LINES 8
`define KLI_OFF_LEVEL_SEL 8'h9c
`define KLI_OFF_LINE_EN 8'h9d
`define KLI_OFF_LINE_FLAG 8'h9e
`define KLI_OFF_CTRL 8'ha0
`define KLI_OFF_STATUS 8'ha1
`define KLI_CTRL_GIE_BIT 0
`define KLI_STAT_PIN_BIT 0
`define KLI_RST_LEVEL_SEL 8'h00
`define KLI_RST_LINE_EN 8'h00
`define KLI_RST_LINE_FLAG 8'h00
`define KLI_RST_CTRL 8'h00
`define KLI_SYNC_STAGES 2
`endif

// [rtl/kli_sync.v]
// two-flop synchroniser bank for the keypad pins
// assumes pins are asynchronous to core_clk
`timescale 1ns/1ps
module kli_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // kli_sync

// [rtl/kli_keypad.v]
// keypad level interrupt block: eight level-detect lines on port one
// assumes a single-cycle register port and a synchronous active-low reset
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "kli_defines.vh"
module kli_keypad #(
  parameter LINES = `KLI_LINES
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register port
  input wire [`KLI_ADDR_W-1:0] reg_addr,
  input wire [`KLI_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`KLI_DATA_W-1:0] reg_rdata,
  // port one pins
  input wire [LINES-1:0] port_one_in,
  // keypad function select per pin
  output wire [LINES-1:0] port_one_key_mode,
  // interrupt and wake
  output wire key_irq,
  output wire key_wake
);
  reg [LINES-1:0] key_level_select_r;
  reg [LINES-1:0] key_line_enable_r;
  reg [LINES-1:0] key_line_flag_r;
  reg [LINES-1:0] key_line_flag_nxt;
  reg keypad_global_irq_enable_r;
  wire [LINES-1:0] pin_sync;
  wire [LINES-1:0] detect;
  wire [LINES-1:0] pending;
  // pins are not trusted until the synchroniser has filled after reset
  reg [`KLI_SYNC_STAGES-1:0] sync_ok_r;

  function [`KLI_DATA_W-1:0] kli_pad;
    input [LINES-1:0] v;
    begin
      kli_pad = {`KLI_DATA_W{1'b0}};
      kli_pad[LINES-1:0] = v;
    end
  endfunction

  kli_sync #(
    .WIDTH(LINES)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(port_one_in),
    .sync_out(pin_sync)
  );

  // level match: xnor of pin and select
  // no false low detect from the cleared synchroniser right after reset
  assign detect = sync_ok_r[`KLI_SYNC_STAGES-1] ?
    ~(pin_sync ^ key_level_select_r) : {LINES{1'b0}};

  always @(posedge core_clk)
  begin
    if (!rst_n)
      sync_ok_r <= {`KLI_SYNC_STAGES{1'b0}};
    else
      sync_ok_r <= {sync_ok_r[`KLI_SYNC_STAGES-2:0], 1'b1};
  end
  assign pending = key_line_flag_r & key_line_enable_r;
  assign key_irq = keypad_global_irq_enable_r & (|pending);
  // wake skips the global enable; its path runs through the flag, which is clocked by core_clk
  assign key_wake = |pending;
  assign port_one_key_mode = key_line_enable_r;

  // flag update: set wins over software clear
  always @*
  begin
    key_line_flag_nxt = key_line_flag_r;
    if (reg_wr && reg_addr == `KLI_OFF_LINE_FLAG)
      key_line_flag_nxt = reg_wdata[LINES-1:0] & key_line_flag_r;
    key_line_flag_nxt = key_line_flag_nxt | detect;
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      key_level_select_r <= `KLI_RST_LEVEL_SEL;
      key_line_enable_r <= `KLI_RST_LINE_EN;
      key_line_flag_r <= `KLI_RST_LINE_FLAG;
      keypad_global_irq_enable_r <= 1'b0;
    end
    else
    begin
      key_line_flag_r <= key_line_flag_nxt;
      if (reg_wr)
      begin
        case (reg_addr)
          `KLI_OFF_LEVEL_SEL: key_level_select_r <= reg_wdata[LINES-1:0];
          `KLI_OFF_LINE_EN: key_line_enable_r <= reg_wdata[LINES-1:0];
          `KLI_OFF_CTRL: keypad_global_irq_enable_r <= reg_wdata[`KLI_CTRL_GIE_BIT];
          default: ;
        endcase
      end
    end
  end

  // read data one cycle after strobe
  always @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= {`KLI_DATA_W{1'b0}};
    else if (reg_rd)
    begin
      case (reg_addr)
        `KLI_OFF_LEVEL_SEL: reg_rdata <= kli_pad(key_level_select_r);
        `KLI_OFF_LINE_EN: reg_rdata <= kli_pad(key_line_enable_r);
        `KLI_OFF_LINE_FLAG: reg_rdata <= kli_pad(key_line_flag_r);
        `KLI_OFF_CTRL: reg_rdata <= {{(`KLI_DATA_W-1){1'b0}}, keypad_global_irq_enable_r};
        `KLI_OFF_STATUS: reg_rdata <= kli_pad(pin_sync);
        default: reg_rdata <= {`KLI_DATA_W{1'b0}};
      endcase
    end
    else
      reg_rdata <= {`KLI_DATA_W{1'b0}};
  end
endmodule // kli_keypad

// [bench/kli_keys.sv]
// key matrix model: a pressed key pulls its line low, pull-ups hold the rest high
`timescale 1ns/1ps
module kli_keys (
  input wire [7:0] press,
  output wire [7:0] port_one_in
);
  assign port_one_in = ~press;
endmodule // kli_keys

// [bench/kli_keypad_asserts.sv]
// port checks for kli_keypad, bound to every instance of it
`timescale 1ns/1ps
module kli_chk #(parameter LINES = 8) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire [LINES-1:0] port_one_key_mode,
  input wire key_irq,
  input wire key_wake
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_irq_wake: assert property (key_irq |-> key_wake) else $error("irq");
  a_irq_hold: assert property (key_irq && !reg_wr |=> key_irq) else $error("irq");
  a_wake_en: assert property (key_wake |-> |port_one_key_mode) else $error("mask");
  a_wake_hold: assert property (key_wake && !reg_wr |=> key_wake) else $error("flag");
  a_mode_hold: assert property (!reg_wr |=> $stable(port_one_key_mode)) else $error("mode");
  a_rst_zero: assert property ($rose(rst_n) |-> !port_one_key_mode) else $error("reset");
  a_en_write:
    assert property (reg_wr && reg_addr == 8'h9d |=> port_one_key_mode == $past(reg_wdata))
      else $error("enable");
  a_gie_off:
    assert property (reg_wr && reg_addr == 8'ha0 && !reg_wdata[0] |=> !key_irq) else $error("gie");
endmodule // kli_chk
bind kli_keypad kli_chk #(.LINES(LINES)) u_chk (.*);

// [bench/tb.sv]
// bench for kli_keypad over its register port, key matrix model on port one
`timescale 1ns/1ps
module tb;
  reg core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0, press = 0;
  wire [7:0] reg_rdata, port_one_in, port_one_key_mode;
  wire key_irq, key_wake;
  integer mismatches = 0, total_checks = 0, cyc = 0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 2000) summarize(1);
  kli_keys u_keys (.*);
  kli_keypad u_dut (.*);
  task summarize(input hung);
    mismatches = mismatches + hung;
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input [7:0] s, e);
    total_checks = total_checks + 1;
    mismatches = mismatches + (s !== e);
    if (s !== e) $display("BAD %s exp %h got %h", n, e, s);
  endtask
  task bus(input w, input [7:0] a, d);
    @(posedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1 if (!w) chk("rdata", reg_rdata, d);
  endtask
  task t_low;
    bus(1, 8'h9d, 8'h08);
    bus(1, 8'ha0, 8'h01);
    @(posedge core_clk);
    press <= 8'h08;
    repeat (4) @(posedge core_clk);
    press <= 8'h00;
    bus(0, 8'h9e, 8'h08);
    chk("irq", key_irq, 1);
    bus(1, 8'h9e, 8'h00);
  endtask
  task t_high;
    bus(1, 8'h9c, 8'h80);
    bus(1, 8'h9d, 8'h00);
    bus(1, 8'h9e, 8'h00);
    bus(0, 8'h9e, 8'h80);
    bus(1, 8'h9d, 8'h80);
    bus(1, 8'ha0, 8'h00);
    chk("irq", key_irq, 0);
    chk("wake", key_wake, 1);
    chk("mode", port_one_key_mode, 8'h80);
    bus(0, 8'ha0, 8'h00);
    bus(0, 8'ha1, 8'hff);
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1;
    t_low;
    t_high;
    summarize(0);
  end
endmodule // tb
